/* jtp_pkg.sv */
package jtp_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int IR_W   = 4;
  localparam int ID_W   = 32;
  localparam int BSR_W  = 8;
  localparam int NPIN   = 5;
  localparam int SYNC_W = NPIN + 1;

  // ************************************************************
  // shared pin positions on the pad bus
  // ************************************************************
  localparam int PIN_TCK  = 0;
  localparam int PIN_TMS  = 1;
  localparam int PIN_TDI  = 2;
  localparam int PIN_TDO  = 3;
  localparam int PIN_TRST = 4;
  localparam int SYNC_CORE_TDO = NPIN;

  // levels a test input takes while its pin serves general-purpose use
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h16;

  // ************************************************************
  // instruction codes
  // ************************************************************
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_INTEST = 4'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] INS_ABORT  = 4'h8;
  localparam logic [IR_W-1:0] INS_DPACC  = 4'ha;
  localparam logic [IR_W-1:0] INS_APACC  = 4'hb;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'he;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [NPIN-1:0] ALT_FUNCTION_CHOICE_BIT_RST  = 5'h1f;
  localparam logic [NPIN-1:0] COMMIT_RST = 5'h00;
  localparam logic [BSR_W-1:0] BSR_RST   = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jtp_tap_state_t;

  typedef struct packed {
    logic            key_wr;
    logic [31:0]     key;
    logic            commit_wr;
    logic [NPIN-1:0] commit;
    logic            alt_function_choice_bit_wr;
    logic [NPIN-1:0] alt_function_choice_bit;
  } jtp_cfg_req_t;

  typedef struct packed {
    logic [NPIN-1:0] dout;
    logic [NPIN-1:0] oe;
  } jtp_pad_drv_t;

endpackage : jtp_pkg

/* jtp_tap.sv */
`timescale 1ns/10ps

module jtp_tap
  import jtp_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001, // arbitrary value
  parameter logic [31:0] UNLOCK_KEY   = 32'h0000_c3c3  // arbitrary value
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [jtp_pkg::NPIN-1:0]    pad_in,
  output      jtp_pkg::jtp_pad_drv_t       pad_drv,
  input  wire logic                        core_tdo,
  output      logic                        core_sel,
  input  wire jtp_pkg::jtp_cfg_req_t       cfg_req,
  output      logic [jtp_pkg::NPIN-1:0]    pin_alternate_function_select,
  output      logic [jtp_pkg::NPIN-1:0]    pin_commit_enable,
  output      logic                        pin_config_unlocked,
  input  wire jtp_pkg::jtp_pad_drv_t       gpio_drv,
  output      logic [jtp_pkg::NPIN-1:0]    gpio_in,
  input  wire logic [jtp_pkg::BSR_W-1:0]   bsr_pin_in,
  output      logic [jtp_pkg::BSR_W-1:0]   bsr_out,
  output      logic                        extest_en,
  output      logic                        intest_en,
  output      jtp_pkg::jtp_tap_state_t     tap_state
);
  import jtp_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              tck_d_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {core_tdo, pad_in};
      sync2_r <= sync1_r;
    end
  end

  // ************************************************************
  // pin ownership and commit protection
  // ************************************************************
  logic [NPIN-1:0] alt_function_choice_bit_r;
  logic [NPIN-1:0] commit_r;
  logic            unlocked_r;

  wire             key_match   = cfg_req.key == UNLOCK_KEY;
  // only committed pins can change their select bit
  wire [NPIN-1:0]  alt_function_choice_bit_keep  = alt_function_choice_bit_r & ~commit_r;
  wire [NPIN-1:0]  alt_function_choice_bit_nxt   = alt_function_choice_bit_keep | (cfg_req.alt_function_choice_bit & commit_r);
  wire [NPIN-1:0]  pin_s       = sync2_r[NPIN-1:0];
  // a pin given to GPIO leaves the TAP input parked at an idle level
  wire [NPIN-1:0]  test_in     = (pin_s & alt_function_choice_bit_r) | (PIN_IDLE & ~alt_function_choice_bit_r);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      alt_function_choice_bit_r    <= ALT_FUNCTION_CHOICE_BIT_RST;
      commit_r   <= COMMIT_RST;
      unlocked_r <= 1'b0;
    end else begin
      if (cfg_req.key_wr) begin
        unlocked_r <= key_match;
      end
      if (cfg_req.commit_wr && unlocked_r) begin
        commit_r <= cfg_req.commit;
      end
      if (cfg_req.alt_function_choice_bit_wr) begin
        alt_function_choice_bit_r <= alt_function_choice_bit_nxt;
      end
    end
  end

  assign pin_alternate_function_select = alt_function_choice_bit_r;
  assign pin_commit_enable             = commit_r;
  assign pin_config_unlocked           = unlocked_r;
  assign gpio_in                       = pin_s & ~alt_function_choice_bit_r;

  // ************************************************************
  // test clock edges and sampled inputs
  // ************************************************************
  wire tck_s    = test_in[PIN_TCK];
  wire tms_s    = test_in[PIN_TMS];
  wire tdi_s    = test_in[PIN_TDI];
  wire trst_n_s = test_in[PIN_TRST];
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;
  // trst works as a level without any tck edge; the cost is the sync delay
  wire tap_rst  = ~trst_n_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  // ************************************************************
  // TAP state machine
  // ************************************************************
  jtp_tap_state_t state_r;
  jtp_tap_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TLR:    state_nxt = tms_s ? TLR    : RTI;
      RTI:    state_nxt = tms_s ? SEL_DR : RTI;
      SEL_DR: state_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR:  state_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = tms_s ? UPD_DR : PAU_DR;
      PAU_DR: state_nxt = tms_s ? EX2_DR : PAU_DR;
      EX2_DR: state_nxt = tms_s ? UPD_DR : SH_DR;
      UPD_DR: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_IR: state_nxt = tms_s ? TLR    : CAP_IR;
      CAP_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR:  state_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = tms_s ? UPD_IR : PAU_IR;
      PAU_IR: state_nxt = tms_s ? EX2_IR : PAU_IR;
      EX2_IR: state_nxt = tms_s ? UPD_IR : SH_IR;
      UPD_IR: state_nxt = tms_s ? SEL_DR : RTI;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn || tap_rst) begin
      state_r <= TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  assign tap_state = state_r;

  // ************************************************************
  // instruction decode
  // ************************************************************
  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_upd_r;

  wire ins_known = (ir_upd_r == INS_EXTEST) || (ir_upd_r == INS_INTEST) ||
                   (ir_upd_r == INS_SAMPLE) || (ir_upd_r == INS_IDCODE) ||
                   (ir_upd_r == INS_BYPASS) || (ir_upd_r == INS_ABORT)  ||
                   (ir_upd_r == INS_DPACC)  || (ir_upd_r == INS_APACC);
  wire [IR_W-1:0] ins = ins_known ? ir_upd_r : INS_BYPASS;
  wire ins_core   = (ins == INS_ABORT) || (ins == INS_DPACC) || (ins == INS_APACC);
  wire sel_id     = ins == INS_IDCODE;
  wire sel_bsr    = ins == INS_SAMPLE;
  // extest, intest and core instructions fall through to the bypass cell
  wire sel_byp    = !sel_id && !sel_bsr;

  // ************************************************************
  // state decode for chain actions
  // ************************************************************
  wire in_tlr     = state_r == TLR;
  wire cap_ir     = tck_rise && state_r == CAP_IR;
  wire sh_ir      = tck_rise && state_r == SH_IR;
  wire upd_ir     = tck_rise && state_r == UPD_IR;
  wire cap_dr     = tck_rise && state_r == CAP_DR;
  wire sh_dr      = tck_rise && state_r == SH_DR;
  wire upd_dr     = tck_rise && state_r == UPD_DR;
  wire shifting   = state_r == SH_IR || state_r == SH_DR;

  // ************************************************************
  // instruction chain
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn || tap_rst) begin
      ir_sh_r  <= IR_CAPTURE;
      ir_upd_r <= INS_IDCODE;
    end else begin
      if (cap_ir) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
      end
      if (in_tlr) begin
        ir_upd_r <= INS_IDCODE;
      end else if (upd_ir) begin
        ir_upd_r <= ir_sh_r;
      end
    end
  end

  // ************************************************************
  // data chains
  // ************************************************************
  logic             byp_r;
  logic [ID_W-1:0]  id_sh_r;
  logic [BSR_W-1:0] bsr_sh_r;
  logic [BSR_W-1:0] bsr_upd_r;

  always_ff @(posedge clk) begin
    if (!rstn || tap_rst) begin
      byp_r     <= 1'b0;
      id_sh_r   <= '0;
      bsr_sh_r  <= BSR_RST;
      bsr_upd_r <= BSR_RST;
    end else begin
      if (cap_dr && sel_byp) begin
        byp_r <= 1'b0;
      end else if (sh_dr && sel_byp) begin
        byp_r <= tdi_s;
      end
      if (cap_dr && sel_id) begin
        id_sh_r <= IDCODE_VALUE;
      end else if (sh_dr && sel_id) begin
        id_sh_r <= {tdi_s, id_sh_r[ID_W-1:1]};
      end
      if (cap_dr && sel_bsr) begin
        bsr_sh_r <= bsr_pin_in;
      end else if (sh_dr && sel_bsr) begin
        bsr_sh_r <= {tdi_s, bsr_sh_r[BSR_W-1:1]};
      end
      if (upd_dr && sel_bsr) begin
        bsr_upd_r <= bsr_sh_r;
      end
    end
  end

  // extest and intest only expose what the update stage already holds
  assign bsr_out   = bsr_upd_r;
  assign extest_en = ins == INS_EXTEST;
  assign intest_en = ins == INS_INTEST;
  assign core_sel  = ins_core;

  // ************************************************************
  // serial output, launched on the falling test clock
  // ************************************************************
  logic tdo_r;
  logic tdo_oe_r;

  wire own_dr_bit = sel_id ? id_sh_r[0] : (sel_bsr ? bsr_sh_r[0] : byp_r);
  wire own_bit    = (state_r == SH_IR) ? ir_sh_r[0] : own_dr_bit;
  wire core_bit   = sync2_r[SYNC_CORE_TDO];
  wire mux_bit    = (ins_core && state_r == SH_DR) ? core_bit : own_bit;

  always_ff @(posedge clk) begin
    if (!rstn || tap_rst) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r    <= mux_bit;
      tdo_oe_r <= shifting;
    end
  end

  // ************************************************************
  // pad drive: test port or GPIO per pin
  // ************************************************************
  jtp_pad_drv_t test_drv;
  jtp_pad_drv_t pad_nxt;
  jtp_pad_drv_t pad_r;

  always_comb begin
    test_drv              = '0;
    test_drv.dout[PIN_TDO] = tdo_r;
    test_drv.oe[PIN_TDO]   = tdo_oe_r;
  end

  assign pad_nxt.dout = (test_drv.dout & alt_function_choice_bit_r) | (gpio_drv.dout & ~alt_function_choice_bit_r);
  assign pad_nxt.oe   = (test_drv.oe & alt_function_choice_bit_r) | (gpio_drv.oe & ~alt_function_choice_bit_r);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pad_r <= '0;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign pad_drv = pad_r;

endmodule : jtp_tap

/* jtp_tap_sva.sv */
`timescale 1ns/10ps
module jtp_tap_sva
  import jtp_pkg::*;
#(
  parameter logic [31:0] UNLOCK_KEY = 32'h0000_c3c3 // arbitrary value
) (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic [jtp_pkg::NPIN-1:0] pad_in,
  input wire jtp_pkg::jtp_pad_drv_t    pad_drv,
  input wire logic                     core_sel,
  input wire jtp_pkg::jtp_cfg_req_t    cfg_req,
  input wire logic [jtp_pkg::NPIN-1:0] pin_alternate_function_select,
  input wire logic [jtp_pkg::NPIN-1:0] pin_commit_enable,
  input wire logic                     pin_config_unlocked,
  input wire logic [jtp_pkg::NPIN-1:0] gpio_in,
  input wire logic                     extest_en,
  input wire logic                     intest_en,
  input wire jtp_pkg::jtp_tap_state_t  tap_state
);
  wire logic [NPIN-1:0] af = pin_alternate_function_select;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ********
  // checks
  // ********
  chk_reset_tlr: assert property (disable iff (1'b0)
    !rstn |=> tap_state == TLR && af == ALT_FUNCTION_CHOICE_BIT_RST) else $error("reset left tap or pin select wrong");
  // four samples cover the two sync stages plus the state register
  chk_trst_hold: assert property (
    (!pad_in[PIN_TRST] && af[PIN_TRST])[*4] |-> tap_state == TLR) else $error("tap not held by trst");
  chk_tdo_shift: assert property (
    $rose(pad_drv.oe[PIN_TDO]) && af[PIN_TDO] && $past(af[PIN_TDO]) |-> tap_state inside {SH_DR, SH_IR})
    else $error("tdo driven outside shift");
  chk_tdo_idle: assert property (
    (tap_state == TLR && af[PIN_TDO])[*4] |-> !pad_drv.oe[PIN_TDO]) else $error("tdo driven in reset state");
  chk_tlr_idcode: assert property (
    (tap_state == TLR)[*2] |-> !core_sel && !extest_en && !intest_en) else $error("default instruction wrong");
  chk_unlock_key: assert property (
    cfg_req.key_wr |=> pin_config_unlocked == ($past(cfg_req.key) == UNLOCK_KEY)) else $error("unlock wrong");
  chk_commit_gate: assert property (
    $changed(pin_commit_enable) |-> $past(cfg_req.commit_wr) && $past(pin_config_unlocked))
    else $error("commit changed while locked");
  chk_alt_function_choice_bit_gate: assert property (
    $changed(af) |-> $past(cfg_req.alt_function_choice_bit_wr) && ((af ^ $past(af)) & ~$past(pin_commit_enable)) == '0)
    else $error("uncommitted select bit changed");
  chk_gpio_mask: assert property ((gpio_in & af) == '0) else $error("test pin seen as gpio");
  cover property (tap_state == SH_DR && core_sel);
  cover property ($rose(pin_config_unlocked));
  cover property ($fell(af[PIN_TCK]));
endmodule : jtp_tap_sva

bind jtp_tap jtp_tap_sva #(.UNLOCK_KEY(UNLOCK_KEY)) u_sva (
  .clk(clk), .rstn(rstn), .pad_in(pad_in), .pad_drv(pad_drv), .core_sel(core_sel), .cfg_req(cfg_req),
  .pin_alternate_function_select(pin_alternate_function_select), .pin_commit_enable(pin_commit_enable),
  .pin_config_unlocked(pin_config_unlocked), .gpio_in(gpio_in), .extest_en(extest_en),
  .intest_en(intest_en), .tap_state(tap_state)
);

/* jtp_tester.sv */
`timescale 1ns/10ps
module jtp_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  // ********
  // probe
  // ********
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // inputs move with the fall, tdo is taken just before the rise
  task automatic cyc(input logic m, input logic d, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #65;
    o = tdo;
    tck = 1'b1;
    #60;
  endtask : cyc
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask : set_trst
  task automatic tlr5();
    logic o;
    repeat (5) cyc(1'b1, 1'b1, o);
  endtask : tlr5
  // starts and ends in run-test-idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    cyc(1'b1, 1'b1, o);
    if (ir)
      cyc(1'b1, 1'b1, o);
    cyc(1'b0, 1'b1, o);
    cyc(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    cyc(1'b1, 1'b1, o);
    cyc(1'b0, 1'b1, o);
  endtask : scan
endmodule : jtp_tester

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import jtp_pkg::*;
  localparam logic [31:0] ID  = 32'h0000_1001; // arbitrary value
  localparam logic [31:0] KEY = 32'h0000_c3c3; // arbitrary value
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  logic           core_tdo = 1'b0;
  jtp_cfg_req_t   cfg = '0;
  jtp_pad_drv_t   pdrv;
  jtp_pad_drv_t   gdrv = '0;
  logic [7:0]     bsr_in = '0;
  logic [7:0]     bsr_q;
  logic [4:0]     afs, cen, gin, ext_lvl, pad;
  logic           unl, csel, ext, intt, tck, tms, tdi, trst_n;
  jtp_tap_state_t st;
  int             failures = 0;
  int             n_tests = 0;
  always #5 clk = ~clk;
  // a released tdo pin sits at its pull-up level; the other released pins follow the tester
  assign ext_lvl = {trst_n, 1'b1, tdi, tms, tck};
  assign pad = (pdrv.oe & pdrv.dout) | (~pdrv.oe & ext_lvl);
  jtp_tap #(.IDCODE_VALUE(ID), .UNLOCK_KEY(KEY)) dut (
    .clk(clk), .rstn(rstn), .pad_in(pad), .pad_drv(pdrv), .core_tdo(core_tdo), .core_sel(csel),
    .cfg_req(cfg), .pin_alternate_function_select(afs), .pin_commit_enable(cen),
    .pin_config_unlocked(unl), .gpio_drv(gdrv), .gpio_in(gin), .bsr_pin_in(bsr_in),
    .bsr_out(bsr_q), .extest_en(ext), .intest_en(intt), .tap_state(st)
  );
  jtp_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(pad[PIN_TDO]));
  // ********
  // checking
  // ********
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_state(input jtp_tap_state_t got, input jtp_tap_state_t exp);
    chk_val({28'h0, got}, {28'h0, exp});
  endtask : chk_state
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  function automatic logic is_core(input logic [3:0] c);
    return c == INS_ABORT || c == INS_DPACC || c == INS_APACC;
  endfunction : is_core
  function automatic logic [31:0] exp_dr(input logic [3:0] c, input logic [31:0] d, input logic k,
                                         input logic [7:0] b);
    if (c == INS_IDCODE)
      return ID;
    if (c == INS_SAMPLE)
      return {d[23:0], b};
    if (is_core(c))
      return {32{k}};
    return {d[30:0], 1'b0};
  endfunction : exp_dr
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    logic [31:0] d, q;
    logic [7:0]  b;
    logic [4:0]  ea, ec, pa;
    logic        eu, o;
    int          seed;
    seed = $urandom(71);
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    chk_val({unl, cen, afs, bsr_q}, {1'b0, COMMIT_RST, ALT_FUNCTION_CHOICE_BIT_RST, BSR_RST});
    chk_state(st, TLR);
    repeat (3) @(negedge clk);
    #2.5;
    tester.cyc(1'b0, 1'b1, o);
    for (int c = 0; c < 16; c++) begin
      core_tdo = 1'($urandom);
      bsr_in = 8'($urandom);
      d = $urandom;
      tester.scan(1'b1, IR_W, 32'(c), q);
      chk_val({28'h0, q[3:0]}, {28'h0, IR_CAPTURE});
      chk_val({29'h0, csel, ext, intt}, {29'h0, is_core(c[3:0]), c == 0, c == 1});
      b = bsr_q;
      tester.scan(1'b0, ID_W, d, q);
      chk_val(q, exp_dr(c[3:0], d, core_tdo, bsr_in));
      chk_val({24'h0, bsr_q}, {24'h0, (c == 2) ? d[31:24] : b});
    end
    tester.tlr5();
    chk_state(st, TLR);
    tester.cyc(1'b0, 1'b1, o);
    tester.scan(1'b0, ID_W, 32'($urandom), q);
    chk_val(q, ID);
    tester.cyc(1'b1, 1'b1, o);
    tester.cyc(1'b0, 1'b1, o);
    tester.cyc(1'b0, 1'b1, o);
    tester.set_trst(1'b0);
    #100;
    chk_state(st, TLR);
    repeat (3) tester.cyc(1'b0, 1'b1, o);
    chk_state(st, TLR);
    chk_val({31'h0, pdrv.oe[PIN_TDO]}, 32'h0);
    tester.set_trst(1'b1);
    ea = ALT_FUNCTION_CHOICE_BIT_RST;
    ec = '0;
    eu = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      cfg.key = (i == 0 || $urandom_range(1)) ? KEY : 32'($urandom);
      cfg.commit = 5'($urandom);
      cfg.alt_function_choice_bit = 5'($urandom);
      gdrv = 10'($urandom);
      case ((i < 3) ? i : $urandom_range(2))
        0: cfg.key_wr = 1'b1;
        1: cfg.commit_wr = 1'b1;
        default: cfg.alt_function_choice_bit_wr = 1'b1;
      endcase
      // the pad register takes the new gpio drive with the select bits held before this write
      pa = ea;
      if (cfg.commit_wr && eu)
        ec = cfg.commit;
      if (cfg.alt_function_choice_bit_wr)
        ea = (cfg.alt_function_choice_bit & ec) | (ea & ~ec);
      if (cfg.key_wr)
        eu = cfg.key == KEY;
      @(negedge clk);
      cfg = '0;
      chk_val({21'h0, unl, cen, afs}, {21'h0, eu, ec, ea});
      chk_val({22'h0, pdrv.dout & ~pa, pdrv.oe & ~pa}, {22'h0, gdrv.dout & ~pa, gdrv.oe & ~pa});
    end
    gdrv = '0;
    repeat (4) @(negedge clk);
    chk_val({27'h0, gin}, {27'h0, ext_lvl & ~ea});
    final_report();
  end
endmodule : testbench
